// ===== bench/acrb_host.sv
// Host model driving the serial configuration port
`default_nettype none
module acrb_host (
	input  wire logic clk_in,
	input  wire logic sdo_in,
	output var logic  cs_n_out,
	output var logic  sclk_out,
	output var logic  sdi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wait_clk
	// Header then n bytes, first byte in bits 7:0; six clocks per sclk phase
	task automatic xfer(input logic rd, input logic [14:0] adr, input int n,
			input logic [31:0] wd, output logic [31:0] rdat);
		logic [23:0] hdr;
		int          j;
		hdr = {rd, 8'h00, adr};
		rdat = '0;
		wait_clk(1);
		cs_n_out = 1'b0;
		wait_clk(6);
		for (int i = 0; i < 24 + 8 * n; i++) begin
			j = 8 * ((i - 24) / 8) + 7 - (i - 24) % 8;
			if (i < 24)
				sdi_out = hdr[23 - i];
			else
				sdi_out = rd ? ~sdi_out : wd[j];
			wait_clk(6);
			if (i >= 24)
				rdat[j] = sdo_in;
			sclk_out = 1'b1;
			wait_clk(6);
			sclk_out = 1'b0;
		end
		wait_clk(6);
		cs_n_out = 1'b1;
		wait_clk(8);
	endtask : xfer
endmodule : acrb_host
`default_nettype wire

// ===== bench/adc_config_register_bank_tb.sv
// Self-checking bench for the configuration register bank
`default_nettype none
module adc_config_register_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MAKER = 16'h5A3C; // Arbitrary value
	localparam logic [23:0] POS   = 24'h3C5A96;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cs_n, sclk, sdi, sdo, sdo_oe, al_in, ev, recv, proc, mag;
	logic        dpecl, apecl, flip, byp, tsen, tspecl;
	logic [3:0]  sel;
	logic [15:0] fsa, fsb;
	logic [23:0] pos = POS;
	logic [31:0] rv, dummy;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          n_ev = 0;
	int          n_oe = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (ev === 1'b1) n_ev++;
	always @(posedge clk) if (sdo_oe === 1'b1) n_oe++;
	acrb_host host (.clk_in(clk), .sdo_in(sdo), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));
	acrb_top #(.MAKER_ID(MAKER)) dut (
		.clk_in                          (clk),
		.rst_n_in                        (rst_n),
		.spi_cs_n_in                     (cs_n),
		.spi_sclk_in                     (sclk),
		.spi_sdi_in                      (sdi),
		.spi_sdo_out                     (sdo),
		.spi_sdo_oe_out                  (sdo_oe),
		.alignment_in                    (al_in),
		.alignment_edge_position_in      (pos),
		.alignment_event_out             (ev),
		.alignment_receiver_enable_out   (recv),
		.alignment_processor_enable_out  (proc),
		.capture_position_magnify_out    (mag),
		.alignment_delay_select_out      (sel),
		.sample_clock_pecl_enable_out    (dpecl),
		.alignment_pecl_enable_out       (apecl),
		.alignment_polarity_flip_out     (flip),
		.full_scale_adjust_a_out         (fsa),
		.full_scale_adjust_b_out         (fsb),
		.reference_bypass_out            (byp),
		.timestamp_input_enable_out      (tsen),
		.timestamp_input_pecl_enable_out (tspecl)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
		host.xfer(1'b0, a, n, d, dummy);
	endtask : wr
	task automatic rd(input logic [14:0] a, input int n);
		host.xfer(1'b1, a, n, 32'h0, rv);
	endtask : rd
	task automatic pulse(input logic lvl);
		al_in = lvl;
		host.wait_clk(12);
	endtask : pulse
	task automatic t_reset_values;
		rd(acrb_pkg::ADR_CLK0, 2);
		chk(rv, 32'h2000);
		chk(sdo_oe, 1'b0);
		rd(acrb_pkg::ADR_FSA, 4);
		chk(rv, 32'hA000A000);
		chk(fsb, 16'hA000);
		rd(acrb_pkg::ADR_BYP, 1);
		chk(rv, 32'h0);
		rd(acrb_pkg::ADR_TS, 1);
		chk(rv, 32'h0);
		rd(acrb_pkg::ADR_USR, 1);
		chk(rv, 32'h0);
		rd(acrb_pkg::ADR_CFG_A, 1);
		chk(rv, 32'h30);
		chk({recv, proc, mag, sel}, 32'h0);
	endtask : t_reset_values
	task automatic t_identity;
		n_oe = 0;
		rd(acrb_pkg::ADR_MAKER, 2);
		chk(rv, MAKER);
		chk(n_oe != 0, 1'b1);
		n_oe = 0;
		wr(acrb_pkg::ADR_MAKER, 2, 32'hFFFF);
		chk(n_oe, 32'd0);
		rd(acrb_pkg::ADR_MAKER, 2);
		chk(rv, MAKER);
		wr(15'h000E, 1, 32'h55);
		rd(15'h000E, 1);
		chk(rv, 32'h0);
	endtask : t_identity
	task automatic t_streaming;
		wr(acrb_pkg::ADR_FSA, 4, 32'h44332211);
		chk({fsb, fsa}, 32'h44332211);
		wr(acrb_pkg::ADR_CFG_A, 1, 32'h00);
		wr(15'h0033, 2, 32'h5566);
		chk(fsb, 16'h6655);
		wr(acrb_pkg::ADR_CFG_A, 1, 32'h20);
	endtask : t_streaming
	task automatic t_freeze;
		wr(acrb_pkg::ADR_USR, 1, 32'h01);
		wr(acrb_pkg::ADR_TS, 3, 32'h020100);
		chk({tspecl, tsen}, 2'b10);
		rd(acrb_pkg::ADR_POS, 3);
		chk(rv, {8'h00, {3{POS[7:0]}}});
		wr(acrb_pkg::ADR_USR, 1, 32'h00);
		wr(acrb_pkg::ADR_POS, 1, 32'hFF);
		rd(acrb_pkg::ADR_POS, 3);
		chk(rv, POS);
		pos = 24'h0F1E2D;
		rd(acrb_pkg::ADR_POS, 3);
		chk(rv, 32'h0F1E2D);
		wr(acrb_pkg::ADR_BYP, 1, 32'h01);
		chk(byp, 1'b1);
	endtask : t_freeze
	task automatic t_clock;
		wr(acrb_pkg::ADR_CLK1, 1, 32'h27);
		chk({dpecl, apecl, flip}, 3'b111);
		rd(acrb_pkg::ADR_CLK1, 1);
		chk(rv, 32'h27);
		wr(acrb_pkg::ADR_CLK1, 1, 32'h20);
		wr(acrb_pkg::ADR_CLK0, 1, 32'h3A);
		chk({proc, recv, mag, sel}, 7'h3A);
		n_ev = 0;
		pulse(1'b1);
		pulse(1'b0);
		chk(n_ev, 32'd0);
		wr(acrb_pkg::ADR_CLK0, 1, 32'h60);
		pulse(1'b1);
		pulse(1'b0);
		chk(n_ev, 32'd1);
		pulse(1'b1);
		wr(acrb_pkg::ADR_CLK1, 1, 32'h21);
		n_ev = 0;
		pulse(1'b0);
		pulse(1'b1);
		chk(n_ev, 32'd1);
	endtask : t_clock
	task automatic t_mid_reset;
		host.wait_clk(1);
		rst_n = 1'b0;
		host.wait_clk(8);
		rst_n = 1'b1;
		host.wait_clk(4);
		chk({fsa, fsb}, 32'hA000A000);
		chk({recv, proc, flip, byp, tsen, tspecl}, 32'h0);
		rd(acrb_pkg::ADR_CLK1, 1);
		chk(rv, 32'h20);
	endtask : t_mid_reset
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
	initial begin
		al_in = 1'b0;
		host.wait_clk(8);
		rst_n = 1'b1;
		host.wait_clk(4);
		t_reset_values();
		t_identity();
		t_streaming();
		t_freeze();
		t_clock();
		t_mid_reset();
		print_verdict();
	end
endmodule : adc_config_register_bank_tb
`default_nettype wire

// ===== logic/acrb_pkg.sv
// Constants, field layout and reset values of the configuration register bank
// Functional notes
// - Maker identity at 0x00C-0x00D is read-only, fixed, writes ignored.
// - Without freeze, streaming steps the address in the chosen direction.
// - With freeze set, every streamed byte uses the same address.
// - Freeze is bit 0 of user port config at 0x010, reset 0x00.
// - Alignment events are processed only while processor enable, bit 6, is set.
// - Bit 5 of clock control zero enables the alignment receiver, reset 0.
// - Bit 4 of clock control zero magnifies the capture position view.
// - Bits 3 to 0 of clock control zero select the alignment delay tap.
// - Bit 2 of clock control one sets sample clock PECL mode.
// - Bit 1 of clock control one sets alignment input PECL mode.
// - Bit 0 of clock control one inverts the internal alignment signal.
// - Clock control one at 0x02A resets to 0x20, upper bits 00100.
// - Capture position occupies 0x02C-0x02E, no reset, measured status.
// - Full scale word A at 0x030-0x031 resets to 0xA000.
// - Full scale word B at 0x032-0x033 resets to 0xA000.
// - Reference bypass register at 0x038 resets to 0x00.
// - Timestamp input control register at 0x03B resets to 0x00.
// - Direction bit 5 of config A: 0 decrements, 1 increments, default 1.
// - Capture position is read-only, 24 bits of edge position.
// - Timestamp control bit 0 enables input, bit 1 selects PECL.
`default_nettype none
package acrb_pkg;
	localparam int ADDR_W = 15;
	localparam int HDR_BITS = 24;
	localparam int BYTE_BITS = 8;
	localparam logic [ADDR_W-1:0] ADR_CFG_A   = 15'h0000;
	localparam logic [ADDR_W-1:0] ADR_REV     = 15'h0006;
	localparam logic [ADDR_W-1:0] ADR_MAKER   = 15'h000C;
	localparam logic [ADDR_W-1:0] ADR_USR     = 15'h0010;
	localparam logic [ADDR_W-1:0] ADR_CLK0    = 15'h0029;
	localparam logic [ADDR_W-1:0] ADR_CLK1    = 15'h002A;
	localparam logic [ADDR_W-1:0] ADR_POS     = 15'h002C;
	localparam logic [ADDR_W-1:0] ADR_FSA     = 15'h0030;
	localparam logic [ADDR_W-1:0] ADR_FSB     = 15'h0032;
	localparam logic [ADDR_W-1:0] ADR_BYP     = 15'h0038;
	localparam logic [ADDR_W-1:0] ADR_TS      = 15'h003B;
	localparam int BIT_DIR = 5;
	localparam int BIT_SDO_ACT = 4;
	localparam int BIT_HOLD = 0;
	localparam int BIT_PROC = 6;
	localparam int BIT_RECV = 5;
	localparam int BIT_MAG = 4;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;
	localparam int BIT_DEV_PECL = 2;
	localparam int BIT_ALN_PECL = 1;
	localparam int BIT_FLIP = 0;
	localparam int BIT_BYPASS = 0;
	localparam int BIT_TS_EN = 0;
	localparam int BIT_TS_PECL = 1;
	localparam logic       DIR_RST  = 1'h1;
	localparam logic       HOLD_RST = 1'h0;
	localparam logic [7:0] CLK0_RST = 8'h00;
	localparam logic [7:0] CLK1_RST = 8'h20;
	localparam logic [15:0] FS_RST  = 16'hA000;
	localparam logic [7:0] BYP_RST  = 8'h00;
	localparam logic [7:0] TS_RST   = 8'h00;
	typedef enum logic [1:0] {
		ST_CMD  = 2'b01,
		ST_DATA = 2'b10
	} acrb_state_e;
endpackage : acrb_pkg
`default_nettype wire

// ===== logic/acrb_top.sv
// Configuration register bank behind a 4-wire serial port
`default_nettype none
module acrb_top #(
	parameter logic [15:0] MAKER_ID = 16'h5A3C, // Arbitrary value
	parameter logic [7:0]  REVISION = 8'h11     // Arbitrary value
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        spi_cs_n_in,
	input  wire logic        spi_sclk_in,
	input  wire logic        spi_sdi_in,
	output logic             spi_sdo_out,
	output logic             spi_sdo_oe_out,
	input  wire logic        alignment_in,
	input  wire logic [23:0] alignment_edge_position_in,
	output logic             alignment_event_out,
	output logic             alignment_receiver_enable_out,
	output logic             alignment_processor_enable_out,
	output logic             capture_position_magnify_out,
	output logic [3:0]       alignment_delay_select_out,
	output logic             sample_clock_pecl_enable_out,
	output logic             alignment_pecl_enable_out,
	output logic             alignment_polarity_flip_out,
	output logic [15:0]      full_scale_adjust_a_out,
	output logic [15:0]      full_scale_adjust_b_out,
	output logic             reference_bypass_out,
	output logic             timestamp_input_enable_out,
	output logic             timestamp_input_pecl_enable_out
);

	localparam int AW = acrb_pkg::ADDR_W;

	// Pin synchronisers
	logic [2:0]  pin_s1_r;
	logic [2:0]  pin_s2_r;
	logic        aln_s1_r;
	logic        aln_s2_r;
	logic [23:0] pos_s1_r;
	logic [23:0] pos_s2_r;
	logic        sclk_d_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_s1_r <= 3'h4;
			pin_s2_r <= 3'h4;
			aln_s1_r <= 1'h0;
			aln_s2_r <= 1'h0;
			pos_s1_r <= 24'h000000;
			pos_s2_r <= 24'h000000;
			sclk_d_r <= 1'h0;
		end else begin
			pin_s1_r <= {spi_cs_n_in, spi_sclk_in, spi_sdi_in};
			pin_s2_r <= pin_s1_r;
			aln_s1_r <= alignment_in;
			aln_s2_r <= aln_s1_r;
			pos_s1_r <= alignment_edge_position_in;
			pos_s2_r <= pos_s1_r;
			sclk_d_r <= pin_s2_r[1];
		end
	end

	logic cs_act;
	logic sdi;
	logic sclk_rise;
	logic sclk_fall;

	assign cs_act    = !pin_s2_r[2];
	assign sdi       = pin_s2_r[0];
	assign sclk_rise = cs_act && pin_s2_r[1] && !sclk_d_r;
	assign sclk_fall = cs_act && !pin_s2_r[1] && sclk_d_r;

	// Frame sequencer
	acrb_pkg::acrb_state_e state_r;
	logic [4:0]  cnt_r;
	logic [23:0] sh_r;
	logic        hdr_last;
	logic        byte_done;
	logic [7:0]  rx_byte;

	assign hdr_last  = sclk_rise && state_r == acrb_pkg::ST_CMD
		&& cnt_r == 5'(acrb_pkg::HDR_BITS - 1);
	assign byte_done = sclk_rise && state_r == acrb_pkg::ST_DATA
		&& cnt_r == 5'(acrb_pkg::BYTE_BITS - 1);
	assign rx_byte   = {sh_r[6:0], sdi};

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= acrb_pkg::ST_CMD;
			cnt_r   <= 5'h00;
		end else if (!cs_act) begin
			state_r <= acrb_pkg::ST_CMD;
			cnt_r   <= 5'h00;
		end else if (sclk_rise) begin
			case (state_r)
				acrb_pkg::ST_CMD: begin
					if (hdr_last) begin
						state_r <= acrb_pkg::ST_DATA;
						cnt_r   <= 5'h00;
					end else begin
						cnt_r <= cnt_r + 5'h01;
					end
				end
				acrb_pkg::ST_DATA: begin
					if (byte_done) begin
						cnt_r <= 5'h00;
					end else begin
						cnt_r <= cnt_r + 5'h01;
					end
				end
				default: begin
					state_r <= acrb_pkg::ST_CMD;
					cnt_r   <= 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh_r <= 24'h000000;
		end else if (sclk_rise) begin
			sh_r <= {sh_r[22:0], sdi};
		end
	end

	// Command and streaming address
	logic          rd_r;
	logic [AW-1:0] addr_r;
	logic          dir_up_r;
	logic          hold_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_r <= 1'h0;
		end else if (hdr_last) begin
			rd_r <= sh_r[22];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_r <= '0;
		end else if (hdr_last) begin
			addr_r <= {sh_r[13:0], sdi};
		end else if (byte_done && !hold_r) begin
			if (dir_up_r) begin
				addr_r <= addr_r + AW'(1);
			end else begin
				addr_r <= addr_r - AW'(1);
			end
		end
	end

	// Register writes
	logic        we;
	logic [7:0]  clk0_r;
	logic [7:0]  clk1_r;
	logic [15:0] fsa_r;
	logic [15:0] fsb_r;
	logic [7:0]  byp_r;
	logic [7:0]  ts_r;

	assign we = byte_done && !rd_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dir_up_r <= acrb_pkg::DIR_RST;
			hold_r   <= acrb_pkg::HOLD_RST;
			clk0_r   <= acrb_pkg::CLK0_RST;
			clk1_r   <= acrb_pkg::CLK1_RST;
			fsa_r    <= acrb_pkg::FS_RST;
			fsb_r    <= acrb_pkg::FS_RST;
			byp_r    <= acrb_pkg::BYP_RST;
			ts_r     <= acrb_pkg::TS_RST;
		end else if (we) begin
			if (addr_r == acrb_pkg::ADR_CFG_A) begin
				dir_up_r <= rx_byte[acrb_pkg::BIT_DIR];
			end else if (addr_r == acrb_pkg::ADR_USR) begin
				hold_r <= rx_byte[acrb_pkg::BIT_HOLD];
			end else if (addr_r == acrb_pkg::ADR_CLK0) begin
				clk0_r <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_CLK1) begin
				clk1_r <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_FSA) begin
				fsa_r[7:0] <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_FSA + AW'(1)) begin
				fsa_r[15:8] <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_FSB) begin
				fsb_r[7:0] <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_FSB + AW'(1)) begin
				fsb_r[15:8] <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_BYP) begin
				byp_r <= rx_byte;
			end else if (addr_r == acrb_pkg::ADR_TS) begin
				ts_r <= rx_byte;
			end
		end
	end

	// Read data select
	logic [7:0] rd_data;

	always_comb begin
		rd_data = 8'h00;
		if (addr_r == acrb_pkg::ADR_CFG_A) begin
			rd_data[acrb_pkg::BIT_DIR]     = dir_up_r;
			rd_data[acrb_pkg::BIT_SDO_ACT] = 1'h1;
		end else if (addr_r == acrb_pkg::ADR_REV) begin
			rd_data = REVISION;
		end else if (addr_r == acrb_pkg::ADR_MAKER) begin
			rd_data = MAKER_ID[7:0];
		end else if (addr_r == acrb_pkg::ADR_MAKER + AW'(1)) begin
			rd_data = MAKER_ID[15:8];
		end else if (addr_r == acrb_pkg::ADR_USR) begin
			rd_data[acrb_pkg::BIT_HOLD] = hold_r;
		end else if (addr_r == acrb_pkg::ADR_CLK0) begin
			rd_data = clk0_r;
		end else if (addr_r == acrb_pkg::ADR_CLK1) begin
			rd_data = clk1_r;
		end else if (addr_r == acrb_pkg::ADR_POS) begin
			rd_data = pos_s2_r[7:0];
		end else if (addr_r == acrb_pkg::ADR_POS + AW'(1)) begin
			rd_data = pos_s2_r[15:8];
		end else if (addr_r == acrb_pkg::ADR_POS + AW'(2)) begin
			rd_data = pos_s2_r[23:16];
		end else if (addr_r == acrb_pkg::ADR_FSA) begin
			rd_data = fsa_r[7:0];
		end else if (addr_r == acrb_pkg::ADR_FSA + AW'(1)) begin
			rd_data = fsa_r[15:8];
		end else if (addr_r == acrb_pkg::ADR_FSB) begin
			rd_data = fsb_r[7:0];
		end else if (addr_r == acrb_pkg::ADR_FSB + AW'(1)) begin
			rd_data = fsb_r[15:8];
		end else if (addr_r == acrb_pkg::ADR_BYP) begin
			rd_data = byp_r;
		end else if (addr_r == acrb_pkg::ADR_TS) begin
			rd_data = ts_r;
		end
	end

	// Serial output, changed on falling clock
	logic       load_r;
	logic [7:0] tx_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			load_r <= 1'h0;
			tx_r   <= 8'h00;
		end else begin
			load_r <= hdr_last || byte_done;
			if (load_r) begin
				tx_r <= rd_data;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			spi_sdo_out    <= 1'h0;
			spi_sdo_oe_out <= 1'h0;
		end else begin
			spi_sdo_oe_out <= cs_act && rd_r && state_r == acrb_pkg::ST_DATA;
			if (!cs_act) begin
				spi_sdo_out <= 1'h0;
			end else if (sclk_fall && rd_r && state_r == acrb_pkg::ST_DATA) begin
				spi_sdo_out <= tx_r[~cnt_r[2:0]];
			end
		end
	end

	// Alignment event path
	logic aln_lvl;
	logic aln_d_r;
	logic aln_en;

	assign aln_lvl = aln_s2_r ^ clk1_r[acrb_pkg::BIT_FLIP];
	assign aln_en  = clk0_r[acrb_pkg::BIT_RECV]
		&& clk0_r[acrb_pkg::BIT_PROC];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aln_d_r             <= 1'h0;
			alignment_event_out <= 1'h0;
		end else begin
			aln_d_r             <= aln_lvl;
			alignment_event_out <= aln_en && aln_lvl && !aln_d_r;
		end
	end

	// Control outputs
	assign alignment_receiver_enable_out   = clk0_r[acrb_pkg::BIT_RECV];
	assign alignment_processor_enable_out  = clk0_r[acrb_pkg::BIT_PROC];
	assign capture_position_magnify_out    = clk0_r[acrb_pkg::BIT_MAG];
	assign alignment_delay_select_out      =
		clk0_r[acrb_pkg::SEL_LSB +: acrb_pkg::SEL_W];
	assign sample_clock_pecl_enable_out    = clk1_r[acrb_pkg::BIT_DEV_PECL];
	assign alignment_pecl_enable_out       = clk1_r[acrb_pkg::BIT_ALN_PECL];
	assign alignment_polarity_flip_out     = clk1_r[acrb_pkg::BIT_FLIP];
	assign full_scale_adjust_a_out         = fsa_r;
	assign full_scale_adjust_b_out         = fsb_r;
	assign reference_bypass_out            = byp_r[acrb_pkg::BIT_BYPASS];
	assign timestamp_input_enable_out      = ts_r[acrb_pkg::BIT_TS_EN];
	assign timestamp_input_pecl_enable_out = ts_r[acrb_pkg::BIT_TS_PECL];

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_maker_id_fixed: assert property (
		addr_r == acrb_pkg::ADR_MAKER + AW'(1) |-> rd_data == MAKER_ID[15:8]
	) else $error("maker identity high byte wrong");

	chk_addr_frozen: assert property (
		byte_done && hold_r |=> addr_r == $past(addr_r)
	) else $error("address moved while frozen");

	chk_addr_step_up: assert property (
		byte_done && !hold_r && dir_up_r |=> addr_r == $past(addr_r) + AW'(1)
	) else $error("address did not increment");

	chk_addr_step_down: assert property (
		byte_done && !hold_r && !dir_up_r |=> addr_r == $past(addr_r) - AW'(1)
	) else $error("address did not decrement");

	chk_event_gated: assert property (
		alignment_event_out |-> $past(clk0_r[acrb_pkg::BIT_PROC])
			&& $past(clk0_r[acrb_pkg::BIT_RECV])
	) else $error("alignment event while disabled");

	chk_event_polarity: assert property (
		alignment_event_out |-> $past(aln_s2_r) != $past(clk1_r[acrb_pkg::BIT_FLIP])
	) else $error("alignment event on wrong polarity");

	chk_clk1_write: assert property (
		we && addr_r == acrb_pkg::ADR_CLK1 |=> clk1_r == $past(rx_byte)
	) else $error("clock control one write lost");

	chk_fsa_hold: assert property (
		!we |=> $stable(fsa_r)
	) else $error("full scale A changed without write");

	chk_reserved_zero: assert property (
		addr_r == acrb_pkg::ADR_POS + AW'(3) |-> rd_data == 8'h00
	) else $error("reserved address reads nonzero");

	chk_sdo_quiet: assert property (
		!cs_act |=> !spi_sdo_oe_out && !spi_sdo_out
	) else $error("serial output active without select");

	cov_read_frame: cover property (hdr_last && sh_r[22]);
	cov_write_byte: cover property (we && addr_r == acrb_pkg::ADR_FSA);
	cov_frozen_stream: cover property (byte_done && hold_r ##1 hold_r);
	cov_align_event: cover property (alignment_event_out);

endmodule : acrb_top
`default_nettype wire
